// File: common/tsm_match_if.sv
// Interface between state register and table row matcher.
// Assumes one clock domain; purely combinational signals.
`timescale 1ns/1ps
`include "tsm_regs.svh"
interface tsm_match_if;
	logic [`TSM_IDX_W-1:0] state_index;
	logic [`TSM_NUM_IN-1:0] pattern;
	logic [`TSM_IDX_W-1:0] next_state_index;
	modport fsm (output state_index, output pattern, input next_state_index);
	modport table_side (input state_index, input pattern, output next_state_index);
endinterface : tsm_match_if

// File: common/tsm_pkg.sv
// Types for the table driven state machine.
// Assumes tsm_regs.svh is on the include path.
`include "tsm_regs.svh"
package tsm_pkg;
	typedef logic [`TSM_IDX_W-1:0] tsm_idx_t;
	// Output level encoding
	typedef enum logic [1:0] {
		TSM_LVL_ZERO = 2'h0,
		TSM_LVL_ONE = 2'h1,
		TSM_LVL_UNK = 2'h2
	} tsm_level_e;
	// Output strength encoding
	typedef enum logic [1:0] {
		TSM_STR_STRONG = 2'h0,
		TSM_STR_RES = 2'h1,
		TSM_STR_HIZ = 2'h2,
		TSM_STR_UNDEF = 2'h3
	} tsm_strength_e;
	typedef struct packed {
		tsm_level_e level;
		tsm_strength_e strength;
	} tsm_outval_s;
	// One transition row: care mask, value, destination
	typedef struct packed {
		logic [`TSM_NUM_IN-1:0] care;
		logic [`TSM_NUM_IN-1:0] value;
		tsm_idx_t dest;
	} tsm_row_s;
endpackage : tsm_pkg

// File: common/tsm_regs.svh
// Constants for the table driven state machine.
// Assumes inclusion by bare name from package and modules.
`ifndef TSM_REGS_SVH
`define TSM_REGS_SVH
`define TSM_NUM_IN 2
`define TSM_NUM_OUT 2
`define TSM_NUM_STATE 4
`define TSM_IDX_W 2
`define TSM_RESET_STATE 2'h0
`define TSM_ROWS 4
`define TSM_LVL_W 2
`define TSM_STR_W 2
`define TSM_IN_RESET_BIT 1
`define TSM_IN_DIR_BIT 0
`endif

// File: src/tsm_machine.sv
// Contract
// - Each clock, go to table destination.
// - Reset enters configurable default state, zero.
// - Outputs depend only on current state.
// - Output is level plus strength pair.
// - States are zero-based integer indices.
// - Sample table is 2-bit up/down counter.
//
// Top of the table driven Moore machine.
// Assumes inputs arrive asynchronously and pass a two-stage synchroniser.
`timescale 1ns/1ps
`include "tsm_regs.svh"
module tsm_machine (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// Pattern inputs
	input wire logic [`TSM_NUM_IN-1:0] pattern_in,
	// Outputs
	output logic [`TSM_IDX_W-1:0] state_index,
	output logic [`TSM_NUM_OUT-1:0] out_level,
	output tsm_pkg::tsm_outval_s out_val [`TSM_NUM_OUT]
);
	logic [`TSM_NUM_IN-1:0] pattern_meta;
	logic [`TSM_NUM_IN-1:0] pattern_sync;
	tsm_pkg::tsm_outval_s next_out_val [`TSM_NUM_OUT];
	logic [`TSM_IDX_W-1:0] next_state_index;

	tsm_match_if m ();

	// ************
	// Input synchroniser
	// ************
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			pattern_meta <= '0;
			pattern_sync <= '0;
		end else begin
			pattern_meta <= pattern_in;
			pattern_sync <= pattern_meta;
		end
	end

	assign m.state_index = state_index;
	assign m.pattern = pattern_sync;
	assign next_state_index = m.next_state_index;

	tsm_table u_table (
		.m(m)
	);

	// ************
	// State register
	// ************
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			state_index <= `TSM_RESET_STATE;
		end else begin
			state_index <= next_state_index;
		end
	end

	// ************
	// Output table
	// ************
	// One entry per state; no input term, so the machine stays Moore
	function automatic tsm_pkg::tsm_outval_s out_entry(logic [`TSM_IDX_W-1:0] s, int b);
		tsm_pkg::tsm_outval_s col1;
		tsm_pkg::tsm_outval_s col0;
		col1 = '{level: tsm_pkg::TSM_LVL_ZERO, strength: tsm_pkg::TSM_STR_STRONG};
		col0 = '{level: tsm_pkg::TSM_LVL_ZERO, strength: tsm_pkg::TSM_STR_STRONG};
		case (s)
			2'h0: begin
				col1.level = tsm_pkg::TSM_LVL_ZERO;
				col0.level = tsm_pkg::TSM_LVL_ZERO;
			end
			2'h1: begin
				col1.level = tsm_pkg::TSM_LVL_ZERO;
				col0.level = tsm_pkg::TSM_LVL_ONE;
			end
			2'h2: begin
				col1.level = tsm_pkg::TSM_LVL_ONE;
				col0.level = tsm_pkg::TSM_LVL_ZERO;
			end
			2'h3: begin
				col1.level = tsm_pkg::TSM_LVL_ONE;
				col0.level = tsm_pkg::TSM_LVL_ONE;
			end
			default: begin
				// Unreachable with four states; unknown level makes it visible
				col1.level = tsm_pkg::TSM_LVL_UNK;
				col0.level = tsm_pkg::TSM_LVL_UNK;
			end
		endcase
		out_entry = (b == 0) ? col0 : col1;
	endfunction : out_entry

	genvar g;
	generate
		for (g = 0; g < `TSM_NUM_OUT; g++) begin : g_out
			// Bit 0 of the output vector is the rightmost column
			assign next_out_val[g] = out_entry(next_state_index, g);
			always_ff @(posedge clk_sys or posedge reset) begin
				if (reset) begin
					out_val[g] <= '{level: tsm_pkg::TSM_LVL_ZERO,
						strength: tsm_pkg::TSM_STR_STRONG};
					out_level[g] <= 1'b0;
				end else begin
					// Registered from next state so outputs track state with no lag
					out_val[g] <= next_out_val[g];
					out_level[g] <= next_out_val[g].level == tsm_pkg::TSM_LVL_ONE;
				end
			end
		end
	endgenerate

	// ************
	// Assertions
	// ************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);

	// ************
	// Settle counter for checks
	// ************
	// Pipeline checks skip the edges where the synchroniser still holds reset data
	logic [1:0] settle_cnt;
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			settle_cnt <= 2'h0;
		end else if (settle_cnt != 2'h3) begin
			settle_cnt <= settle_cnt + 2'h1;
		end
	end

	count_up_a: assert property (pattern_sync == 2'h1 |=>
		state_index == 2'($past(state_index) + 2'h1))
		else $error("count up step wrong");
	count_down_a: assert property (pattern_sync == 2'h0 |=>
		state_index == 2'($past(state_index) - 2'h1))
		else $error("count down step wrong");
	sync_reset_a: assert property (pattern_sync[`TSM_IN_RESET_BIT] |=>
		state_index == `TSM_RESET_STATE)
		else $error("sync reset not taken");
	moore_out_a: assert property (out_level == state_index)
		else $error("outputs do not match state");
	strength_a: assert property (out_val[0].strength == tsm_pkg::TSM_STR_STRONG &&
		out_val[1].strength == tsm_pkg::TSM_STR_STRONG)
		else $error("output strength not strong");
	pin_path_a: assert property (pattern_in == 2'h1 ##1 pattern_in == 2'h1
		|=> ##1 state_index == 2'($past(state_index) + 2'h1))
		else $error("pin to state latency wrong");
	range_a: assert property (state_index != `TSM_RESET_STATE |=>
		state_index != $past(state_index))
		else $error("state index did not move");

	// ************
	// Further checks
	// ************
	// Counter behaviour of the sample table, and synchroniser latency
	wrap_up_a: assert property (state_index == 2'h3 && pattern_sync == 2'h1 |=>
		state_index == 2'h0)
		else $error("up wrap wrong");
	wrap_down_a: assert property (state_index == 2'h0 && pattern_sync == 2'h0 |=>
		state_index == 2'h3)
		else $error("down wrap wrong");
	care_low_a: assert property (pattern_sync == 2'h2 |=>
		state_index == `TSM_RESET_STATE)
		else $error("clear with direction low not taken");
	care_high_a: assert property (pattern_sync == 2'h3 |=>
		state_index == `TSM_RESET_STATE)
		else $error("clear with direction high not taken");
	sync_pipe_a: assert property (settle_cnt == 2'h3 |->
		pattern_sync == $past(pattern_in, 2))
		else $error("synchroniser latency wrong");

	// Outputs follow state only
	out_reset_a: assert property (pattern_sync[`TSM_IN_RESET_BIT] |=>
		out_level == 2'h0)
		else $error("outputs not cleared with state");
	out_stable_a: assert property ($stable(state_index) |->
		$stable(out_val[0]) && $stable(out_val[1]))
		else $error("outputs moved without state");
	out_step_a: assert property (pattern_sync == 2'h1 |=>
		out_level == 2'($past(out_level) + 2'h1))
		else $error("outputs did not step with state");
	level_legal_a: assert property (out_val[0].level != tsm_pkg::TSM_LVL_UNK &&
		out_val[1].level != tsm_pkg::TSM_LVL_UNK)
		else $error("unknown level from sample table");
	generate
		for (g = 0; g < `TSM_NUM_OUT; g++) begin : g_lvl
			out_bit_a: assert property (@(posedge clk_sys) disable iff (reset)
				out_level[g] == state_index[g])
				else $error("output bit level wrong");
		end
	endgenerate

	// Reset checks run while reset is held, and on the edge where reset falls
	reset_hold_a: assert property (@(posedge clk_sys) disable iff (1'b0)
		reset && $past(reset) |-> state_index == `TSM_RESET_STATE && out_level == 2'h0)
		else $error("state not held at default in reset");
	sync_clear_a: assert property (@(posedge clk_sys) disable iff (1'b0)
		reset && $past(reset) |-> pattern_sync == 2'h0)
		else $error("synchroniser not cleared in reset");
	outval_reset_a: assert property (@(posedge clk_sys) disable iff (1'b0)
		reset && $past(reset) |-> out_val[0].strength == tsm_pkg::TSM_STR_STRONG)
		else $error("output strength wrong in reset");
	reset_exit_a: assert property (@(posedge clk_sys) $fell(reset) |->
		$past(state_index) == `TSM_RESET_STATE)
		else $error("reset state wrong");

	wrap_up_c: cover property (state_index == 2'h3 ##1 state_index == 2'h0);
	wrap_down_c: cover property (state_index == 2'h0 ##1 state_index == 2'h3);
	sync_rst_c: cover property (state_index == 2'h2 && pattern_sync[1]);
	count_run_c: cover property (state_index == 2'h1 ##1 state_index == 2'h2 ##1 state_index == 2'h3);
	care_c: cover property (pattern_sync == 2'h3 ##1 state_index == 2'h0);
endmodule : tsm_machine

// File: src/tsm_table.sv
// Transition table and row matcher for the sample counter table.
// Assumes inputs on the interface are already synchronised.
`timescale 1ns/1ps
`include "tsm_regs.svh"
module tsm_table (
	// Lookup
	tsm_match_if.table_side m
);
	tsm_pkg::tsm_row_s rows [`TSM_NUM_STATE][`TSM_ROWS];
	logic [`TSM_ROWS-1:0] hit;

	// ************
	// Sample table: 2-bit up/down counter, inputs {reset, dir}
	// ************
	always_comb begin
		for (int s = 0; s < `TSM_NUM_STATE; s++) begin
			rows[s][0] = '{care: 2'h3, value: 2'h0, dest: `TSM_IDX_W'(s - 1)};
			rows[s][1] = '{care: 2'h3, value: 2'h1, dest: `TSM_IDX_W'(s + 1)};
			rows[s][2] = '{care: 2'h2, value: 2'h2, dest: `TSM_RESET_STATE};
			rows[s][3] = '{care: 2'h3, value: 2'h3, dest: `TSM_RESET_STATE};
		end
	end

	function automatic logic row_hit(tsm_pkg::tsm_row_s r, logic [`TSM_NUM_IN-1:0] p);
		row_hit = ((p ^ r.value) & r.care) == '0;
	endfunction : row_hit

	genvar g;
	generate
		for (g = 0; g < `TSM_ROWS; g++) begin : g_hit
			assign hit[g] = row_hit(rows[m.state_index][g], m.pattern);
		end
	endgenerate

	// First matching row wins; no match holds the state
	always_comb begin
		m.next_state_index = m.state_index;
		for (int r = `TSM_ROWS - 1; r >= 0; r--) begin
			if (hit[r]) begin
				m.next_state_index = rows[m.state_index][r].dest;
			end
		end
	end
endmodule : tsm_table

// File: tb/tb_top.sv
// Self-checking bench for the table driven state machine.
// Assumes the package, interface and design sources compile first.
`timescale 1ns/1ps
module tb_top;
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	logic [1:0] want = 2'h0;
	logic [1:0] pattern_in;
	logic [1:0] state_index;
	logic [1:0] out_level;
	tsm_pkg::tsm_outval_s out_val [2];
	int failures = 0;
	int n_checks = 0;
	logic [1:0] prev;
	// Row: pattern {clear, up} then step count
	logic [5:0] rows [5] = '{6'h15, 6'h05, 6'h22, 6'h32, 6'h14};

	tsm_upstream tsm_upstream_i (.clk_sys(clk_sys), .want(want), .pattern_in(pattern_in));
	tsm_machine tsm_machine_i (.clk_sys(clk_sys), .reset(reset), .pattern_in(pattern_in),
		.state_index(state_index), .out_level(out_level), .out_val(out_val));

	initial forever #5 clk_sys = ~clk_sys;

	function automatic logic [1:0] nxt(input logic [1:0] s, input logic [1:0] p);
		return p[1] ? 2'h0 : (p[0] ? s + 2'h1 : s - 2'h1);
	endfunction : nxt

	task automatic check(input logic [3:0] seen, input logic [3:0] exp);
		n_checks++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic outs(input logic [1:0] s);
		check({2'h0, out_level}, {2'h0, s});
		for (int i = 0; i < 2; i++) begin
			check(out_val[i], {s[i] ? tsm_pkg::TSM_LVL_ONE : tsm_pkg::TSM_LVL_ZERO,
				tsm_pkg::TSM_STR_STRONG});
		end
	endtask : outs

	task automatic results;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : results

	// ****************
	// Main sequence
	// ****************
	initial begin
		repeat (5) @(negedge clk_sys);
		reset = 1'b0;
		foreach (rows[r]) begin
			want = rows[r][5:4];
			// Let the new pattern pass the synchroniser first
			repeat (4) @(negedge clk_sys);
			for (int k = 0; k < rows[r][3:0]; k++) begin
				prev = state_index;
				@(negedge clk_sys);
				check({2'h0, state_index}, {2'h0, nxt(prev, want)});
				outs(state_index);
			end
			$display("test row %0d done", r);
		end
		if (state_index == 2'h0)
			@(negedge clk_sys);
		// Asynchronous: no clock edge between assert and check
		reset = 1'b1;
		#1 check({2'h0, state_index}, 4'h0);
		outs(2'h0);
		repeat (2) @(negedge clk_sys);
		reset = 1'b0;
		@(negedge clk_sys);
		check({2'h0, state_index}, 4'h3);
		$display("test reset done");
		results();
	end

	initial begin
		#100000;
		failures++;
		results();
	end
endmodule : tb_top

// File: tb/tsm_upstream.sv
// Upstream logic model that drives the pattern inputs.
// Assumes the bench picks the pattern; changes land on falling edges.
`timescale 1ns/1ps
module tsm_upstream (
	// Clock
	input wire logic clk_sys,
	// Pattern
	input wire logic [1:0] want,
	output logic [1:0] pattern_in
);
	initial pattern_in = 2'h0;
	// Off the sampling edge so the synchroniser never sees a race
	always @(negedge clk_sys) pattern_in <= want;
endmodule : tsm_upstream
